// *** hdl/matrix_key_threshold_detect.sv ***
// ---------------------------------------------------------------
// scan sequencer, converter and per-key decision array
// ---------------------------------------------------------------
module matrix_key_threshold_detect import keyscan_pkg::*; #(
    parameter int DRIFT_BITS = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic [ROWS-1:0] row_drive,
    output logic [COLS-1:0] sample_cap_ctrl_a,
    output logic [COLS-1:0] sample_cap_ctrl_b,
    output logic ramp_en,
    input wire logic [COLS-1:0] col_cmp,
    input wire logic [BURST_W-1:0] burst_len,
    input wire logic [CNT_W-1:0] integ_lim,
    input wire logic [CNT_W-1:0] pos_delay,
    input wire logic [DRIFT_BITS-1:0] drift_div,
    input wire logic setup_we,
    input wire logic setup_sel,
    input wire logic [3:0] setup_key,
    input wire logic [THR_W-1:0] setup_val,
    input wire logic data_taken,
    input wire logic slave_sel_in,
    output logic slave_sel_out,
    output logic slave_sel_oe_n,
    output logic tx_dir,
    output logic data_ready_out,
    output logic data_ready_oe_n,
    output logic activity_n,
    output logic [KEYS-1:0] key_touched
);
    typedef enum logic [2:0] {S_IDLE, S_HIGH, S_LOW, S_CONV, S_NEXT} scan_st_t;

    scan_st_t st_r, st_nxt;
    logic [1:0] row_r, row_nxt;
    logic [1:0] col_r, col_nxt;
    logic [BURST_W-1:0] pulse_r, pulse_nxt;
    logic [7:0] tmr_r, tmr_nxt;
    logic [DRIFT_BITS-1:0] drift_r, drift_nxt;
    logic [KEYS-1:0] touch_r, touch_nxt;
    logic ready_r, ready_nxt;
    logic [THR_W-1:0] neg_thr_r [KEYS];
    logic [THR_W-1:0] pos_thr_r [KEYS];
    logic conv_start, conv_done;
    logic [SIG_W-1:0] conv_val;
    logic [KEYS-1:0] touched_w;
    logic drift_tick;

    // ---------------------------------------------------------------
    // per-key thresholds from the setup port
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int k = 0; k < KEYS; k++) begin
            if (!rst_n) begin
                neg_thr_r[k] <= NEG_THR_RST;
                pos_thr_r[k] <= POS_THR_RST;
            end else if (setup_we && setup_key == 4'(k)) begin
                if (setup_sel) begin
                    pos_thr_r[k] <= setup_val; // see RL9
                end else begin
                    neg_thr_r[k] <= setup_val; // see RL8
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // scan sequencer: one row at a time, whole burst, then convert per column
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        row_nxt = row_r;
        col_nxt = col_r;
        pulse_nxt = pulse_r;
        tmr_nxt = tmr_r;
        conv_start = 1'b0;
        unique case (st_r)
            S_IDLE: begin
                pulse_nxt = '0;
                tmr_nxt = '0;
                // zero burst length would give no charge, so hold off
                if (burst_len != '0) begin
                    st_nxt = S_HIGH;
                end
            end
            S_HIGH: begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r == 8'(PULSE_CYC - 1)) begin
                    tmr_nxt = '0;
                    st_nxt = S_LOW;
                end
            end
            S_LOW: begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r == 8'(PULSE_CYC - 1)) begin
                    tmr_nxt = '0;
                    pulse_nxt = pulse_r + 1'b1;
                    if (pulse_r + 1'b1 >= burst_len) begin // see RL3
                        st_nxt = S_CONV;
                        col_nxt = '0;
                        conv_start = 1'b1;
                    end else begin
                        st_nxt = S_HIGH;
                    end
                end
            end
            S_CONV: begin
                if (conv_done) begin
                    if (col_r == 2'(COLS - 1)) begin
                        st_nxt = S_NEXT;
                    end else begin
                        col_nxt = col_r + 1'b1;
                        conv_start = 1'b1;
                    end
                end
            end
            S_NEXT: begin
                row_nxt = row_r + 1'b1; // see RL2
                st_nxt = S_IDLE;
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            row_r <= '0;
            col_r <= '0;
            pulse_r <= '0;
            tmr_r <= '0;
        end else begin
            st_r <= st_nxt;
            row_r <= row_nxt;
            col_r <= col_nxt;
            pulse_r <= pulse_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // ---------------------------------------------------------------
    // pin drive: one row high during pulse, caps steered per column
    // ---------------------------------------------------------------
    always_comb begin
        row_drive = '0;
        if (st_r == S_HIGH) begin
            row_drive[row_r] = 1'b1; // see RL1
        end
        // a transfers charge during the burst, b dumps during conversion
        sample_cap_ctrl_a = (st_r == S_HIGH || st_r == S_LOW) ? {COLS{1'b1}} : '0;
        sample_cap_ctrl_b = '0;
        if (st_r == S_CONV) begin
            sample_cap_ctrl_b[col_r] = 1'b1;
        end
    end

    slope_adc u_adc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(conv_start),
        .cmp_trip(col_cmp[col_r]),
        .ramp_on(ramp_en),
        .done(conv_done),
        .value(conv_val)
    );

    // drift divider gives the slow slew tick, counting once per full scan of all rows
    always_comb begin
        drift_nxt = drift_r;
        if (st_r == S_NEXT && row_r == 2'(ROWS - 1)) begin
            drift_nxt = (drift_r >= drift_div) ? '0 : drift_r + 1'b1;
        end
    end
    assign drift_tick = (drift_r == drift_div);

    // ---------------------------------------------------------------
    // per-key decision logic
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < KEYS; g++) begin : g_key
            key_track u_key (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .sample_valid(conv_done && {row_r, col_r} == 4'(g)), // see RL4
                .signal(conv_val),
                .neg_thr(neg_thr_r[g]),
                .pos_thr(pos_thr_r[g]),
                .integ_lim(integ_lim),
                .pos_delay(pos_delay),
                .drift_tick(drift_tick),
                .touched(touched_w[g]),
                .reference()
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // host status: change flags data ready until taken
    // ---------------------------------------------------------------
    always_comb begin
        touch_nxt = touched_w;
        ready_nxt = ready_r;
        if (touched_w != touch_r) begin
            ready_nxt = 1'b1; // change wins over a simultaneous take
        end else if (data_taken) begin
            ready_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            drift_r <= '0;
            touch_r <= '0;
            ready_r <= 1'b0;
        end else begin
            drift_r <= drift_nxt;
            touch_r <= touch_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign key_touched = touch_r;
    // open drain: pull low by enabling, release otherwise
    assign data_ready_out = 1'b0;
    assign data_ready_oe_n = !ready_r; // see RL10
    assign slave_sel_out = 1'b0;
    assign slave_sel_oe_n = 1'b1; // device never asserts select in slave mode
    assign tx_dir = !slave_sel_in; // see RL11
    assign activity_n = !(|touch_r); // see RL12
endmodule // matrix_key_threshold_detect

// *** hdl/keyscan_pkg.sv ***
// Operation
// RL1 - four rows driven, four columns sensed, sixteen keys at the crossings.
// RL2 - rows pulsed one after another, each with its whole burst first.
// RL3 - burst pulse count is programmable, acting as signal gain.
// RL4 - each burst is converted by a single-slope ramp into a signal value.
// RL5 - touch is only a downward deviation of signal from reference.
// RL6 - touch only after integrator filtering of a drop of at least threshold.
// RL7 - comparison level recomputed whenever the reference moves.
// RL8 - negative threshold held per key and written through the setup port.
// RL9 - per-key positive threshold; a rise above it leads to recalibration.
// RL10 - open-drain active-low data-ready output for slave serial mode.
// RL11 - slave-select is active low, open drain, sets transfer direction.
// RL12 - active-low status output shows key activity.
// RL13 - integrator counts up on detect samples, clears on any miss before limit.
// RL14 - slow slew tracking of reference only while key has no detection.
// RL15 - after positive delay the reference is loaded with the signal.
// RL16 - reference seeded from the signal at startup before decisions.
package keyscan_pkg;
    localparam int ROWS = 4;
    localparam int COLS = 4;
    localparam int KEYS = ROWS * COLS;
    localparam int SIG_W = 10;
    localparam int THR_W = 8;
    localparam int CNT_W = 4;
    localparam int BURST_W = 6;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [BURST_W-1:0] BURST_LEN_RST = 6'h10;
    localparam logic [THR_W-1:0] NEG_THR_RST = 8'h0A;
    localparam logic [THR_W-1:0] POS_THR_RST = 8'h0A;
    localparam logic [CNT_W-1:0] INTEG_LIM_RST = 4'h2;
    localparam logic [CNT_W-1:0] POS_DELAY_RST = 4'h3;
    localparam logic [7:0] DRIFT_DIV_RST = 8'h08;
    // ---------------------------------------------------------------
    // pulse timing: 1 us half-pulse at 25 ns per cycle
    // ---------------------------------------------------------------
    localparam int PULSE_NS = 1000;
    localparam int CLK_NS = 25;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAMP_MAX = (1 << SIG_W) - 1;
    typedef enum logic [1:0] {PARAM_NEG_THR, PARAM_POS_THR} param_sel_t;
endpackage

// *** hdl/slope_adc.sv ***
// ---------------------------------------------------------------
// single-slope converter: counts ramp cycles until comparator trips
// ---------------------------------------------------------------
module slope_adc import keyscan_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic cmp_trip,
    output logic ramp_on,
    output logic done,
    output logic [SIG_W-1:0] value
);
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [SIG_W-1:0] cnt_r, cnt_nxt;
    logic [SIG_W-1:0] val_r, val_nxt;

    // ramp counts until trip or full scale
    always_comb begin
        busy_nxt = busy_r;
        cnt_nxt = cnt_r;
        val_nxt = val_r;
        done_nxt = 1'b0;
        if (start) begin
            busy_nxt = 1'b1;
            cnt_nxt = '0;
        end else if (busy_r) begin
            if (cmp_trip || cnt_r == SIG_W'(RAMP_MAX)) begin // see RL4
                busy_nxt = 1'b0;
                val_nxt = cnt_r;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= '0;
            val_r <= '0;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            cnt_r <= cnt_nxt;
            val_r <= val_nxt;
        end
    end

    assign ramp_on = busy_r;
    assign done = done_r;
    assign value = val_r;
endmodule // slope_adc

// *** hdl/key_track.sv ***
// ---------------------------------------------------------------
// per-key reference, integrator and recalibration state
// ---------------------------------------------------------------
module key_track import keyscan_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [SIG_W-1:0] signal,
    input wire logic [THR_W-1:0] neg_thr,
    input wire logic [THR_W-1:0] pos_thr,
    input wire logic [CNT_W-1:0] integ_lim,
    input wire logic [CNT_W-1:0] pos_delay,
    input wire logic drift_tick,
    output logic touched,
    output logic [SIG_W-1:0] reference
);
    logic seeded_r, seeded_nxt;
    logic det_r, det_nxt;
    logic [CNT_W-1:0] integ_r, integ_nxt;
    logic [CNT_W-1:0] pos_cnt_r, pos_cnt_nxt;
    logic [SIG_W-1:0] ref_r, ref_nxt;
    logic [SIG_W:0] neg_level;
    logic [SIG_W:0] pos_level;
    logic below, above;

    // levels follow the reference directly, so any reference move re-derives them
    assign neg_level = {1'b0, ref_r} - (SIG_W+1)'(neg_thr); // see RL7
    assign pos_level = {1'b0, ref_r} + (SIG_W+1)'(pos_thr);
    // only downward swings count toward touch; underflow means unreachable
    assign below = !neg_level[SIG_W] && ({1'b0, signal} <= neg_level); // see RL5
    assign above = {1'b0, signal} > pos_level; // see RL9

    always_comb begin
        seeded_nxt = seeded_r;
        det_nxt = det_r;
        integ_nxt = integ_r;
        pos_cnt_nxt = pos_cnt_r;
        ref_nxt = ref_r;
        if (sample_valid) begin
            if (!seeded_r) begin
                ref_nxt = signal; // see RL16
                seeded_nxt = 1'b1;
            end else begin
                if (below && integ_lim != '0) begin
                    if (integ_r < integ_lim) begin
                        integ_nxt = integ_r + 1'b1; // see RL13
                    end
                    if (integ_r + 1'b1 >= integ_lim) begin
                        det_nxt = 1'b1; // see RL6
                    end
                end else if (det_r) begin
                    // release waits for the count to fall back to zero
                    integ_nxt = (integ_r == '0) ? '0 : integ_r - 1'b1;
                    if (integ_r <= 1) begin
                        det_nxt = 1'b0;
                    end
                end else begin
                    integ_nxt = '0; // see RL13
                end
                if (above && !det_r && pos_delay != '0) begin
                    pos_cnt_nxt = pos_cnt_r + 1'b1;
                    if (pos_cnt_r + 1'b1 >= pos_delay) begin
                        ref_nxt = signal; // see RL15
                        pos_cnt_nxt = '0;
                    end
                end else begin
                    pos_cnt_nxt = '0;
                    // slow slew only while no detection is held
                    if (drift_tick && !det_r && !below) begin // see RL14
                        if (signal > ref_r) begin
                            ref_nxt = ref_r + 1'b1;
                        end else if (signal < ref_r) begin
                            ref_nxt = ref_r - 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seeded_r <= 1'b0;
            det_r <= 1'b0;
            integ_r <= '0;
            pos_cnt_r <= '0;
            ref_r <= '0;
        end else begin
            seeded_r <= seeded_nxt;
            det_r <= det_nxt;
            integ_r <= integ_nxt;
            pos_cnt_r <= pos_cnt_nxt;
            ref_r <= ref_nxt;
        end
    end

    assign touched = det_r && seeded_r;
    assign reference = ref_r;
endmodule // key_track

// *** tb/key_matrix_model.sv ***
// ---------------------------------------------------------------
// passive 4x4 electrode matrix with per-column comparators
// ---------------------------------------------------------------
module key_matrix_model import keyscan_pkg::*; (
    input wire logic clk_sys,
    input wire logic [ROWS-1:0] row_drive,
    input wire logic [COLS-1:0] sample_cap_ctrl_b,
    input wire logic ramp_en,
    output logic [COLS-1:0] col_cmp
);
    timeunit 1ns;
    timeprecision 100ps;
    // charge seen at each crossing, in ramp steps; a finger lowers it
    logic [SIG_W-1:0] sig [KEYS];
    logic [1:0] row_r;
    logic [COLS-1:0] cb_r;
    logic [SIG_W-1:0] ramp_r;
    logic [1:0] col;

    // remember which row was burst last, and restart the ramp per column
    always_ff @(posedge clk_sys) begin
        for (int r = 0; r < ROWS; r++) begin
            if (row_drive[r]) begin
                row_r <= r[1:0];
            end
        end
        cb_r <= sample_cap_ctrl_b;
        ramp_r <= (ramp_en && sample_cap_ctrl_b == cb_r) ? ramp_r + 1'b1 : '0;
    end

    // comparator trips once the ramp reaches the stored charge
    always_comb begin
        col = 2'h0;
        for (int c = 0; c < COLS; c++) begin
            if (sample_cap_ctrl_b[c]) begin
                col = c[1:0];
            end
        end
        col_cmp = (ramp_en && ramp_r >= sig[{row_r, col}]) ? sample_cap_ctrl_b : 4'h0;
    end
endmodule // key_matrix_model

// *** tb/keyscan_sva.sv ***
// ---------------------------------------------------------------
// port checker for the scan and decision block
// ---------------------------------------------------------------
module keyscan_sva import keyscan_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ROWS-1:0] row_drive,
    input wire logic [COLS-1:0] sample_cap_ctrl_b,
    input wire logic ramp_en,
    input wire logic data_taken,
    input wire logic slave_sel_in,
    input wire logic slave_sel_oe_n,
    input wire logic tx_dir,
    input wire logic data_ready_out,
    input wire logic data_ready_oe_n,
    input wire logic activity_n,
    input wire logic [KEYS-1:0] key_touched
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // a pulse must hold its row for well over a few cycles
    sequence s_pulse_start;
        $rose(|row_drive);
    endsequence
    sequence s_pulse_hold;
        $stable(row_drive)[*8];
    endsequence
    a_row_one_hot: assert property ($onehot0(row_drive)) else $error("two rows driven");
    a_pulse_holds: assert property (s_pulse_start |=> s_pulse_hold) else $error("pulse too short");
    a_ramp_no_burst: assert property (ramp_en |-> row_drive == 4'h0) else $error("ramp during burst");
    a_ramp_one_col: assert property (ramp_en ##1 ramp_en |-> $onehot(sample_cap_ctrl_b))
        else $error("ramp column not one-hot");
    a_sel_released: assert property (slave_sel_oe_n) else $error("select driven");
    a_dir_follows: assert property (tx_dir == !slave_sel_in) else $error("direction wrong");
    a_ready_od: assert property (data_ready_out == 1'b0) else $error("ready drives high");
    a_ready_raise: assert property ($changed(key_touched) |-> ##[0:2] !data_ready_oe_n)
        else $error("ready not raised");
    // a change registered at the take edge keeps ready, so only a take with no change there must clear
    a_ready_clear: assert property (data_taken ##1 $stable(key_touched) |-> data_ready_oe_n)
        else $error("ready not cleared");
    a_act_on: assert property ((|key_touched) ##1 (|key_touched) |-> !activity_n)
        else $error("activity off while touched");
    a_act_off: assert property ((key_touched == 16'h0000) [*2] |-> activity_n)
        else $error("activity on while idle");
endmodule // keyscan_sva

bind matrix_key_threshold_detect keyscan_sva u_sva (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .row_drive(row_drive),
    .sample_cap_ctrl_b(sample_cap_ctrl_b),
    .ramp_en(ramp_en),
    .data_taken(data_taken),
    .slave_sel_in(slave_sel_in),
    .slave_sel_oe_n(slave_sel_oe_n),
    .tx_dir(tx_dir),
    .data_ready_out(data_ready_out),
    .data_ready_oe_n(data_ready_oe_n),
    .activity_n(activity_n),
    .key_touched(key_touched)
);

// *** tb/testbench.sv ***
module testbench import keyscan_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [SIG_W-1:0] BASE = 10'h03C;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ROWS-1:0] row_drive;
    logic [COLS-1:0] sample_cap_ctrl_a, sample_cap_ctrl_b, col_cmp;
    logic ramp_en, slave_sel_out, slave_sel_oe_n, tx_dir, data_ready_out, data_ready_oe_n, activity_n;
    logic setup_we = 1'b0, setup_sel = 1'b0, data_taken = 1'b0, slave_sel_in = 1'b1;
    logic [BURST_W-1:0] burst_len = 6'h01;
    logic [CNT_W-1:0] integ_lim = INTEG_LIM_RST, pos_delay = POS_DELAY_RST;
    logic [7:0] drift_div = 8'hFF;
    logic [3:0] setup_key = 4'h0;
    logic [THR_W-1:0] setup_val = 8'h00;
    logic [KEYS-1:0] key_touched;
    int miscompares = 0;
    int num_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    matrix_key_threshold_detect u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .row_drive(row_drive),
        .sample_cap_ctrl_a(sample_cap_ctrl_a), .sample_cap_ctrl_b(sample_cap_ctrl_b), .ramp_en(ramp_en),
        .col_cmp(col_cmp), .burst_len(burst_len), .integ_lim(integ_lim), .pos_delay(pos_delay),
        .drift_div(drift_div), .setup_we(setup_we), .setup_sel(setup_sel), .setup_key(setup_key),
        .setup_val(setup_val), .data_taken(data_taken), .slave_sel_in(slave_sel_in),
        .slave_sel_out(slave_sel_out), .slave_sel_oe_n(slave_sel_oe_n), .tx_dir(tx_dir),
        .data_ready_out(data_ready_out), .data_ready_oe_n(data_ready_oe_n), .activity_n(activity_n),
        .key_touched(key_touched));
    key_matrix_model u_mat (.clk_sys(clk_sys), .row_drive(row_drive),
        .sample_cap_ctrl_b(sample_cap_ctrl_b), .ramp_en(ramp_en), .col_cmp(col_cmp));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // inputs always change one step after the rising edge
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    // ends at the first row-0 pulse after row 3, so burst length cannot fool it
    task automatic wait_scan(input int n);
        repeat (n) begin
            do @(negedge clk_sys); while (!row_drive[3]);
            do @(negedge clk_sys); while (!row_drive[0]);
        end
    endtask

    task automatic set_thr(input logic sel, input logic [3:0] key, input logic [7:0] val);
        tick();
        setup_we = 1'b1;
        setup_sel = sel;
        setup_key = key;
        setup_val = val;
        tick();
        setup_we = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        check(16'(activity_n), 16'h0001);
        check(16'(data_ready_oe_n), 16'h0001);
        check({14'h0, slave_sel_oe_n, slave_sel_out}, 16'h0002);
        slave_sel_in = 1'b0;
        tick();
        check(16'(tx_dir), 16'h0001);
        slave_sel_in = 1'b1;
        tick();
        check(16'(tx_dir), 16'h0000);
        // key 0 sits far below the others yet is seeded, so never touched
        wait_scan(3);
        check(key_touched, 16'h0000);
        $display("test reset done");
    endtask

    // two pulses per row, rows strictly in order, then back to row 0
    task automatic t_scan();
        tick();
        burst_len = 6'h02;
        wait_scan(2);
        for (int i = 1; i <= 8; i++) begin
            do @(negedge clk_sys); while (row_drive != 4'h0);
            do @(negedge clk_sys); while (row_drive == 4'h0);
            check(16'(row_drive), 16'(4'h1 << ((i / 2) % 4)));
            check(16'(sample_cap_ctrl_a), 16'h000F);
        end
        // a zero burst length must park the sequencer: no row pulse and no ramp
        tick();
        burst_len = 6'h00;
        repeat (500) tick();
        check({11'h0, ramp_en, row_drive}, 16'h0000);
        burst_len = 6'h01;
        $display("test scan done");
    endtask

    task automatic t_touch();
        u_mat.sig[5] = 10'h028;
        u_mat.sig[6] = 10'h034;
        wait_scan(4);
        check(key_touched, 16'h0020);
        check({14'h0, activity_n, data_ready_oe_n}, 16'h0000);
        tick();
        data_taken = 1'b1;
        tick();
        data_taken = 1'b0;
        tick();
        tick();
        check(16'(data_ready_oe_n), 16'h0001);
        u_mat.sig[5] = BASE;
        u_mat.sig[6] = BASE;
        wait_scan(4);
        check(key_touched, 16'h0000);
        check(16'(activity_n), 16'h0001);
        $display("test touch done");
    endtask

    // same small drop on two keys, only the key with the lowered threshold fires
    task automatic t_thr();
        set_thr(1'b0, 4'h6, 8'h03);
        u_mat.sig[6] = 10'h034;
        u_mat.sig[9] = 10'h034;
        wait_scan(4);
        check(key_touched, 16'h0040);
        u_mat.sig[6] = BASE;
        u_mat.sig[9] = BASE;
        wait_scan(4);
        check(key_touched, 16'h0000);
        $display("test threshold done");
    endtask

    // a rise recalibrates key 3 only; falling back then reads as a touch there
    task automatic t_pos();
        set_thr(1'b1, 4'h2, 8'h40);
        u_mat.sig[2] = 10'h05A;
        u_mat.sig[3] = 10'h05A;
        wait_scan(5);
        check(key_touched, 16'h0000);
        u_mat.sig[2] = BASE;
        u_mat.sig[3] = BASE;
        wait_scan(4);
        check(key_touched, 16'h0008);
        u_mat.sig[3] = 10'h05A;
        wait_scan(4);
        check(key_touched, 16'h0000);
        $display("test positive done");
    endtask

    // a tick every scan lets a slow fall be tracked, so a later small drop stays untouched
    task automatic t_drift();
        tick();
        drift_div = 8'h00;
        u_mat.sig[10] = 10'h037;
        wait_scan(7);
        u_mat.sig[10] = 10'h02E;
        wait_scan(3);
        check(key_touched, 16'h0000);
        $display("test drift done");
    endtask

    // ---------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ---------------------------------------------------------------
    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        for (int k = 0; k < KEYS; k++) begin
            u_mat.sig[k] = BASE;
        end
        u_mat.sig[0] = 10'h014;
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_reset();
        t_scan();
        t_touch();
        t_thr();
        t_pos();
        t_drift();
        results();
    end

    // some fifty scans of about 1400 cycles are expected
    initial begin
        repeat (90000) @(posedge clk_sys);
        miscompares++;
        results();
    end
endmodule // testbench
